// ---- hw/csa_defs.vh ----
// Purpose: constants of the charger state, regulation loop and limit
//          alert register bank
// Assumes: 16-bit registers reached by 8-bit sub-address
// Notes:   phase and loop codes are the encodings on the core-side inputs
`ifndef CSA_DEFS_VH
`define CSA_DEFS_VH

// register sub-addresses
`define CSA_OFF_PHASE      8'h34
`define CSA_OFF_LOOP       8'h35
`define CSA_OFF_ALERT      8'h36

// reset values
`define CSA_RST_REG        16'h0000

// charger phase codes on CHG_PHASE; one-hot bit = code - 1
`define CSA_PH_NONE        4'h0
`define CSA_PH_SHORT       4'h1
`define CSA_PH_MISSING     4'h2
`define CSA_PH_MAXTIME     4'h3
`define CSA_PH_CXTERM      4'h4
`define CSA_PH_TMRTERM     4'h5
`define CSA_PH_NTCPAUSE    4'h6
`define CSA_PH_BULK        4'h7
`define CSA_PH_PRECOND     4'h8
`define CSA_PH_SUSPEND     4'h9
`define CSA_PH_ABSORB      4'hA
`define CSA_PH_EQUALIZE    4'hB

// regulation loop codes on CHG_LOOP
`define CSA_LOOP_NONE      3'h0
`define CSA_LOOP_VBAT      3'h1
`define CSA_LOOP_ICHG      3'h2
`define CSA_LOOP_IIN       3'h3
`define CSA_LOOP_UV        3'h4

// loop indicator bit positions
`define CSA_LB_VBAT        0
`define CSA_LB_ICHG        1
`define CSA_LB_IIN         2
`define CSA_LB_UV          3

// limit alert bit positions
`define CSA_AB_MEAS_VALID  15
`define CSA_AB_QCNT_LO     13

// implemented bits of each register
`define CSA_PHASE_MASK     16'h07FF
`define CSA_LOOP_MASK      16'h000F
`define CSA_ALERT_MASK     16'hBFFF

`endif

// ---- hw/csa_bank.v ----
// Operation
// - state register is 16-bit read-only, at most one bit, 15:11 zero
// - bit 10 marks equalization phase, bit 9 marks absorb phase
// - bit 8 marks charger suspended, not charging
// - bit 7 marks preconditioning, bit 6 marks bulk constant-current phase
// - bit 5 marks pause for thermistor temperature
// - bit 4 timer termination, bit 3 low-current termination
// - bit 2 max charge time, bit 1 missing battery, bit 0 short
// - loop register read-only, exclusive bits, only while charging
// - loop bit 3 marks input undervoltage loop regulating
// - loop bit 2 marks input current limit loop regulating
// - loop bit 1 marks charge current loop regulating
// - loop bit 0 marks battery voltage loop regulating
// - an alert bit sets only while its enable bit is set
// - writing zero to an alert bit clears it
// - alert stays set until cleared or disabled
// - alert bit 15 sets when measurements first become valid
// - bit 13 charge count low, bit 12 charge count high
// - bit 11 battery voltage low, bit 10 battery voltage high
// - bit 9 input voltage low, bit 8 input voltage high
// - bit 7 system voltage low, bit 6 system voltage high
// - bit 5 input current high, bit 4 battery current low
// - bit 3 die temperature high, bit 2 series resistance high
// - bit 1 thermistor ratio high (cold), bit 0 low (hot)
//
// Purpose: charger phase, regulation loop and limit alert registers
// Assumes: register port driven by the serial slave on CORE_CLK
// Notes:   comparator results arrive as levels from the measurement logic
`timescale 1ns/1ps
`include "csa_defs.vh"

module csa_bank (
	input  wire        CORE_CLK,
	input  wire        SYS_RST,
	input  wire [7:0]  REG_ADDR,
	input  wire        REG_WR,
	input  wire [15:0] REG_WDATA,
	input  wire        REG_RD,
	output reg  [15:0] REG_RDATA,
	output reg         REG_RVALID,
	input  wire [3:0]  CHG_PHASE,
	input  wire [2:0]  CHG_LOOP,
	input  wire        MEAS_VALID,
	input  wire [13:0] LIMIT_TRIP,
	input  wire [15:0] LIMIT_EN,
	output wire        LIMIT_ALERT_ANY
);
	reg  [15:0] phase_ff;
	reg  [15:0] nxt_phase;
	reg  [15:0] loop_ff;
	reg  [15:0] nxt_loop;
	reg  [15:0] alert_ff;
	reg  [15:0] nxt_alert;
	reg         meas_valid_ff;
	reg  [15:0] nxt_rdata;
	reg         charging;
	wire        meas_rise;
	wire [15:0] trip_vec;
	wire [15:0] clr_vec;
	wire        alert_wr;

	// phase decode; one code drives one bit so exclusivity is structural
	always @* begin
		nxt_phase = `CSA_RST_REG;
		charging  = 1'b0;
		case (CHG_PHASE)
			`CSA_PH_SHORT: begin
				nxt_phase[0] = 1'b1;
			end
			`CSA_PH_MISSING: begin
				nxt_phase[1] = 1'b1;
			end
			`CSA_PH_MAXTIME: begin
				nxt_phase[2] = 1'b1;
			end
			`CSA_PH_CXTERM: begin
				nxt_phase[3] = 1'b1;
			end
			`CSA_PH_TMRTERM: begin
				nxt_phase[4] = 1'b1;
			end
			`CSA_PH_NTCPAUSE: begin
				nxt_phase[5] = 1'b1;
			end
			`CSA_PH_BULK: begin
				nxt_phase[6] = 1'b1;
				charging     = 1'b1;
			end
			`CSA_PH_PRECOND: begin
				nxt_phase[7] = 1'b1;
				charging     = 1'b1;
			end
			`CSA_PH_SUSPEND: begin
				nxt_phase[8] = 1'b1;
			end
			`CSA_PH_ABSORB: begin
				nxt_phase[9] = 1'b1;
				charging     = 1'b1;
			end
			`CSA_PH_EQUALIZE: begin
				nxt_phase[10] = 1'b1;
				charging      = 1'b1;
			end
			default: begin
				// idle and unused codes leave every bit clear
				nxt_phase = `CSA_RST_REG;
			end
		endcase
	end

	// loop decode, gated so no bit shows outside a charging phase
	always @* begin
		nxt_loop = `CSA_RST_REG;
		if (charging) begin
			case (CHG_LOOP)
				`CSA_LOOP_UV: begin
					nxt_loop[`CSA_LB_UV] = 1'b1;
				end
				`CSA_LOOP_IIN: begin
					nxt_loop[`CSA_LB_IIN] = 1'b1;
				end
				`CSA_LOOP_ICHG: begin
					nxt_loop[`CSA_LB_ICHG] = 1'b1;
				end
				`CSA_LOOP_VBAT: begin
					nxt_loop[`CSA_LB_VBAT] = 1'b1;
				end
				default: begin
					nxt_loop = `CSA_RST_REG;
				end
			endcase
		end
	end

	// only the rising edge counts, so a clear stays cleared while valid
	assign meas_rise = MEAS_VALID & ~meas_valid_ff;

	// trip bits 13:0 map straight onto alert bits 13:0; bit 14 unused
	assign trip_vec = {meas_rise, 1'b0, LIMIT_TRIP};
	// the map above also
	// and

	assign alert_wr = REG_WR & (REG_ADDR == `CSA_OFF_ALERT);
	assign clr_vec  = alert_wr ? ~REG_WDATA : 16'h0000;

	// a trip in the clearing cycle wins, so no event is lost;
	// dropping the enable clears the bit as well
	always @* begin
		nxt_alert = ((alert_ff & ~clr_vec) | trip_vec)
			& LIMIT_EN
			& `CSA_ALERT_MASK;
	end

	// read mux; unmapped addresses answer zero
	always @* begin
		case (REG_ADDR)
			`CSA_OFF_PHASE: begin
				nxt_rdata = phase_ff & `CSA_PHASE_MASK;
			end
			`CSA_OFF_LOOP: begin
				nxt_rdata = loop_ff & `CSA_LOOP_MASK;
			end
			`CSA_OFF_ALERT: begin
				nxt_rdata = alert_ff;
			end
			default: begin
				nxt_rdata = `CSA_RST_REG;
			end
		endcase
	end

	always @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			phase_ff      <= `CSA_RST_REG;
			loop_ff       <= `CSA_RST_REG;
			alert_ff      <= `CSA_RST_REG;
			meas_valid_ff <= 1'b0;
			REG_RDATA     <= `CSA_RST_REG;
			REG_RVALID    <= 1'b0;
		end else begin
			phase_ff      <= nxt_phase;
			loop_ff       <= nxt_loop;
			alert_ff      <= nxt_alert;
			meas_valid_ff <= MEAS_VALID;
			REG_RVALID    <= REG_RD;
			if (REG_RD) begin
				REG_RDATA <= nxt_rdata;
			end
		end
	end

	assign LIMIT_ALERT_ANY = |alert_ff;

endmodule

// ---- dv/csa_host.sv ----
// Purpose: register port master standing in for the serial host
// Assumes: one request per call, taken at the second edge
// Notes:   strobes drop after the taking edge, never before
`timescale 1ns/1ps
module csa_host (
	input  logic        clk,
	output logic [7:0]  a,
	output logic        w,
	output logic        r,
	output logic [15:0] d
);
	initial {a, w, r, d} = 0;
	// a write of zero to an alert bit is how software acks it
	task op(input logic iw, ir, input logic [7:0] ad, input logic [15:0] dt);
		@(posedge clk) {a, w, r, d} <= {ad, iw, ir, dt};
		@(posedge clk) {w, r} <= 2'b00;
	endtask
endmodule

// ---- dv/csa_bank_checker.sv ----
// Purpose: port checks of the phase, loop and alert bank
// Assumes: one clock, async active-high reset
// Notes:   bound from tb
`timescale 1ns/1ps
module csa_chk (
	input logic        CORE_CLK,
	input logic        SYS_RST,
	input logic [7:0]  REG_ADDR,
	input logic        REG_WR,
	input logic        REG_RD,
	input logic [15:0] REG_WDATA,
	input logic [15:0] REG_RDATA,
	input logic        REG_RVALID,
	input logic [3:0]  CHG_PHASE,
	input logic        MEAS_VALID,
	input logic [13:0] LIMIT_TRIP,
	input logic [15:0] LIMIT_EN,
	input logic        LIMIT_ALERT_ANY
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);
	sequence s_rd(x); REG_RD && REG_ADDR == x; endsequence
	property p_rv; REG_RVALID == $past(REG_RD); endproperty
	property p_ph; s_rd(8'h34) |=> $onehot0(REG_RDATA) && !REG_RDATA[15:11];
	endproperty
	property p_lp; s_rd(8'h35) |=> $onehot0(REG_RDATA) && !REG_RDATA[15:4];
	endproperty
	property p_bulk; s_rd(8'h34) ##0 $stable(CHG_PHASE) && CHG_PHASE == 4'h7
		|=> REG_RDATA == 16'h0040; endproperty
	property p_set; (LIMIT_EN[13:0] & LIMIT_TRIP) != 0 |=> LIMIT_ALERT_ANY;
	endproperty
	property p_off; LIMIT_EN == 0 |=> !LIMIT_ALERT_ANY; endproperty
	property p_hold; LIMIT_ALERT_ANY && !REG_WR && $stable(LIMIT_EN)
		|=> LIMIT_ALERT_ANY; endproperty
	property p_clr; REG_WR && REG_ADDR == 8'h36 && REG_WDATA == 0 && !LIMIT_TRIP
		&& $stable(MEAS_VALID) |=> !LIMIT_ALERT_ANY; endproperty
	property p_meas; $rose(MEAS_VALID) && LIMIT_EN[15] |=> LIMIT_ALERT_ANY;
	endproperty
	a_rv: assert property (p_rv) else $error("rvalid misplaced");
	a_ph: assert property (p_ph) else $error("phase bits");
	a_lp: assert property (p_lp) else $error("loop bits");
	a_bulk: assert property (p_bulk) else $error("bulk bit");
	a_set: assert property (p_set) else $error("no set");
	a_off: assert property (p_off) else $error("disabled");
	a_hold: assert property (p_hold) else $error("lost");
	a_clr: assert property (p_clr) else $error("no clear");
	a_meas: assert property (p_meas) else $error("valid");
endmodule

// ---- dv/tb.sv ----
// Purpose: self-checking bench of the phase, loop and alert bank
// Assumes: host model drives the register port
// Notes:   status inputs change by nba at the rising edge
`timescale 1ns/1ps
module tb;
	logic CORE_CLK = 0, SYS_RST = 1, MEAS_VALID = 0, REG_WR, REG_RD;
	logic REG_RVALID, LIMIT_ALERT_ANY;
	logic [7:0] REG_ADDR;
	logic [15:0] REG_WDATA, REG_RDATA, e, en, LIMIT_EN = 0;
	logic [3:0] CHG_PHASE = 0;
	logic [2:0] CHG_LOOP = 0;
	logic [13:0] LIMIT_TRIP = 0;
	int miscompares = 0, n_checks = 0, cyc = 0, c, l;
	int seed = 32'he00c_a5fd, cs[4] = '{7, 8, 10, 11};
	always #2.5 CORE_CLK = ~CORE_CLK;
	csa_bank dut_u (.*);
	csa_host host_u (.clk(CORE_CLK), .a(REG_ADDR), .w(REG_WR), .r(REG_RD),
		.d(REG_WDATA));
	task chk(input string s, input logic [15:0] x, g);
		n_checks++;
		if (g !== x) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", s, x, g);
		end
	endtask
	task rd(input logic [7:0] a, input logic [15:0] x, input string s);
		host_u.op(0, 1, a, 0);
		#1 chk(s, x, REG_RDATA);
		chk("rvalid", 16'h0001, {15'h0000, REG_RVALID});
	endtask
	function logic [15:0] f_ph(int k);
		return (k > 0 && k < 12) ? 16'h0001 << (k - 1) : 16'h0000;
	endfunction
	function logic [15:0] f_lp(int k, int m);
		return (k inside {7, 8, 10, 11} && m inside {[1:4]}) ?
			16'h0001 << (m - 1) : 16'h0000;
	endfunction
	task wrap_up;
		if (miscompares == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge CORE_CLK) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			wrap_up;
		end
	end
	initial begin
		repeat (4) @(posedge CORE_CLK);
		SYS_RST <= 0;
		for (c = 0; c < 16; c++) begin
			@(posedge CORE_CLK) CHG_PHASE <= c;
			rd(8'h34, f_ph(c), "phase");
		end
		for (int i = 0; i < 16; i++) begin
			c = (i < 8) ? cs[$random(seed) & 3] : $random(seed) & 15;
			l = i % 8;
			@(posedge CORE_CLK) {CHG_PHASE, CHG_LOOP} <= {c[3:0], l[2:0]};
			rd(8'h35, f_lp(c, l), "loop");
		end
		rd(8'h37, 0, "unmapped");
		host_u.op(1, 0, 8'h34, 16'hFFFF);
		rd(8'h34, f_ph(c), "phase ro");
		// random enables also cover the disabled case of some bits
		for (int n = 0; n < 16; n++) begin
			en = $random(seed);
			e = (n == 14) ? 16'h0000 : en & (16'h0001 << n);
			@(posedge CORE_CLK) LIMIT_EN <= en;
			MEAS_VALID <= 0;
			host_u.op(1, 0, 8'h36, 16'h0000);
			@(posedge CORE_CLK) LIMIT_TRIP <= 14'h0001 << n;
			MEAS_VALID <= (n == 15);
			@(posedge CORE_CLK) LIMIT_TRIP <= 0;
			host_u.op(1, 0, 8'h36, 16'hFFFF);
			rd(8'h36, e, "alert");
			chk("any", {15'h0000, |e}, {15'h0000, LIMIT_ALERT_ANY});
			host_u.op(1, 0, 8'h36, ~e);
			rd(8'h36, 0, "cleared");
			chk("any clr", 16'h0000, {15'h0000, LIMIT_ALERT_ANY});
		end
		wrap_up;
	end
endmodule
bind csa_bank csa_chk chk_u (.*);
